// File: design/tpu_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef TPU_MAP_SVH
`define TPU_MAP_SVH
`define TPU_COUNT_IDX      8'h01
`define TPU_CONFIG_IDX     8'h81
`define TPU_CTRL_IDX       8'h02
`define TPU_STATUS_IDX     8'h03
`define TPU_CONFIG_RST     8'hff
`define TPU_PUD_BIT        7
`define TPU_IRQEDGE_BIT    6
`define TPU_SRC_BIT        5
`define TPU_EDGE_BIT       4
`define TPU_OWNER_BIT      3
`define TPU_RATE_LSB       0
`define TPU_RATE_MSB       2
`define TPU_PHASES         4
`define TPU_IRQ_LATENCY    4
`endif

// File: design/tpu_pkg.sv
// types shared by the timer prescaler unit
package tpu_pkg;
  typedef struct packed {
    logic       pullup_disable;
    logic       ext_irq_edge_select;
    logic       count_source_select;
    logic       count_edge_select;
    logic       prescaler_owner_select;
    logic [2:0] prescale_ratio_field;
  } tpu_config_t;
  typedef enum logic [1:0] {
    TPU_Q1, TPU_Q2, TPU_Q3, TPU_Q4
  } tpu_phase_t;
endpackage

// File: design/tpu_timer.sv
// timer/counter with shared prescaler, option register, APB slave
// Function
// - count source bit: 1 external pin, 0 instruction-cycle clock
// - edge bit 4: 1 counts falling, 0 counts rising pin edges
// - owner bit 3: 1 prescaler to watchdog, 0 to timer
// - rate code 000..111 gives timer 1:2..1:256, watchdog 1:1..1:128
// - bit 6 selects external interrupt edge: 1 rising, 0 falling
// - bit 7 set disables all pull-ups, else per port latch
// - option register at 81h, all eight bits read and write
// - option register resets to all ones
// - prescaler output sampled on phases Q2 and Q4
// - prescaler divides pin like a ripple counter, symmetrical output
// - counter increments after synchronisation delay, not on edge
// - clock pin shares port bit 4, open-drain output
// - overflow flag sampled on phase Q1 each instruction cycle
// - overflow interrupt latency four instruction cycles
// - one 8-bit counter is prescaler or postscaler, never both
// - count write clears prescaler while timer owns it
// - watchdog clear clears prescaler while watchdog owns it
// - prescaler count is neither readable nor writable
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "tpu_map.svh"
module tpu_timer #(
  parameter int unsigned CW = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port4_in,
  input  wire logic        port4_out,
  output logic             port4_oe_n,
  input  wire logic        watchdog_tick,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        ext_interrupt_pin,
  input  wire logic [7:0]  second_io_port_latch,
  output logic      [7:0]  second_io_pullup_en,
  output logic             watchdog_timeout,
  output logic             timer_irq,
  output logic             ext_irq,
  output logic             instr_clock_output
);
  // register state, one always_ff per concern below
  tpu_pkg::tpu_config_t cfg_ff;
  tpu_pkg::tpu_phase_t  phase_ff;
  tpu_pkg::tpu_phase_t  nxt_phase;
  logic [CW-1:0] count_ff;
  logic [7:0]    presc_ff;
  logic [7:0]    nxt_presc;
  logic          pin_ff;
  logic          presc_out_ff;
  logic          sync_ff;
  logic          sync_d_ff;
  logic          flag_ff;
  logic          irq_en_ff;
  logic          eirq_flag_ff;
  logic          eirq_ff;
  logic [2:0]    lat_ff;
  logic          lat_run_ff;
  logic          wd_out_ff;
  logic          wr_acc;
  logic          rd_acc;
  logic [9:0]    word;
  logic          mapped;
  logic          pin_edge;
  logic          presc_src;
  logic          presc_bit;
  logic          wd_bit;
  logic          inc;
  logic          presc_clr;
  logic          flag_set;
  logic          flag_clr;
  logic          eirq_edge;
  logic [CW-1:0] nxt_count;
  logic          raw_level;

  // apb decode; zero-wait slave, unmapped word reads zero with error
  assign word    = paddr[11:2];
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  // unaligned byte addresses alias onto the same word
  assign mapped  = (word == 10'(`TPU_COUNT_IDX)) ||
                   (word == 10'(`TPU_CONFIG_IDX)) ||
                   (word == 10'(`TPU_CTRL_IDX)) ||
                   (word == 10'(`TPU_STATUS_IDX));
  assign pslverr = psel && penable && !mapped;

  // open-drain pin: port driver pulls low, never drives high
  assign port4_oe_n = port4_out;

  // option register, full read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `TPU_CONFIG_RST;
    end else if (wr_acc && word == 10'(`TPU_CONFIG_IDX)) begin
      cfg_ff <= pwdata[7:0];
    end
  end

  // own control word: bit0 timer interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= 1'b0;
    end else if (wr_acc && word == 10'(`TPU_CTRL_IDX)) begin
      irq_en_ff <= pwdata[0];
    end
  end

  // four internal phases make one instruction cycle
  always_comb begin
    case (phase_ff)
      tpu_pkg::TPU_Q1: nxt_phase = tpu_pkg::TPU_Q2;
      tpu_pkg::TPU_Q2: nxt_phase = tpu_pkg::TPU_Q3;
      tpu_pkg::TPU_Q3: nxt_phase = tpu_pkg::TPU_Q4;
      tpu_pkg::TPU_Q4: nxt_phase = tpu_pkg::TPU_Q1;
      default:         nxt_phase = tpu_pkg::TPU_Q1;
    endcase
  end

  // instruction clock high in Q3 and Q4, registered to stay glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff           <= tpu_pkg::TPU_Q1;
      instr_clock_output <= 1'b0;
    end else begin
      phase_ff           <= nxt_phase;
      instr_clock_output <= (nxt_phase == tpu_pkg::TPU_Q3) ||
                            (nxt_phase == tpu_pkg::TPU_Q4);
    end
  end

  // pin edge detect; edge bit chooses falling (1) or rising (0)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= port4_in;
    end
  end
  assign pin_edge = cfg_ff.count_edge_select ?
                    (pin_ff && !port4_in) :
                    (!pin_ff && port4_in);

  // prescaler input: chosen timer source, or the watchdog tick
  assign presc_src = cfg_ff.prescaler_owner_select ? watchdog_tick :
                     (cfg_ff.count_source_select ? pin_edge :
                      (phase_ff == tpu_pkg::TPU_Q4));
  // clearing follows whichever side owns the prescaler now
  assign presc_clr = cfg_ff.prescaler_owner_select ?
                     watchdog_clear_instr :
                     (wr_acc && word == 10'(`TPU_COUNT_IDX));
  assign nxt_presc = presc_ff + 8'h01;

  // prescaler counter, no software path in or out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= 8'h00;
    end else if (presc_clr) begin
      presc_ff <= 8'h00;
    end else if (presc_src) begin
      presc_ff <= nxt_presc;
    end
  end

  // bit n toggles each 2^n inputs, period 2^(n+1): square, symmetrical output
  assign presc_bit = presc_ff[cfg_ff.prescale_ratio_field];

  // undivided path: the chosen pin edge shows as a rising level
  assign raw_level = cfg_ff.count_edge_select ?
                     !port4_in : port4_in;

  // output toward the synchroniser; raw pin level when undivided
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_out_ff <= 1'b1;
    end else if (!cfg_ff.count_source_select) begin
      presc_out_ff <= 1'b0;
    end else if (cfg_ff.prescaler_owner_select) begin
      presc_out_ff <= raw_level;
    end else begin
      presc_out_ff <= presc_bit;
    end
  end

  // sample on Q2 and Q4; increment on the sampled rise, hence the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // start high: the first sample after reset is never taken as a rise
      sync_ff   <= 1'b1;
      sync_d_ff <= 1'b1;
    end else if (phase_ff == tpu_pkg::TPU_Q2 ||
                 phase_ff == tpu_pkg::TPU_Q4) begin
      sync_ff   <= presc_out_ff;
      sync_d_ff <= sync_ff;
    end
  end

  always_comb begin
    inc = 1'b0;
    if (!cfg_ff.count_source_select) begin
      // internal clock: at Q4, every instruction cycle undivided, else when the selected bit falls
      inc = (phase_ff == tpu_pkg::TPU_Q4) &&
            (cfg_ff.prescaler_owner_select ||
             (presc_ff[cfg_ff.prescale_ratio_field] &&
              !presc_bit_next_same()));
    end else begin
      // external pin, divided or not, always through the Q2/Q4 samples
      inc = sync_ff && !sync_d_ff &&
            (phase_ff == tpu_pkg::TPU_Q1 ||
             phase_ff == tpu_pkg::TPU_Q3);
    end
  end

  // value the selected bit takes after this input; low after high means it falls
  function automatic logic presc_bit_next_same();
    presc_bit_next_same = nxt_presc[cfg_ff.prescale_ratio_field];
  endfunction

  // watchdog postscaler: 1:1 at code 000, so one bit lower than timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_out_ff <= 1'b0;
    end else begin
      // without the postscaler the watchdog sees every tick
      wd_out_ff <= cfg_ff.prescaler_owner_select ?
                   wd_bit : watchdog_tick;
    end
  end
  assign wd_bit = (cfg_ff.prescale_ratio_field == 3'h0) ? watchdog_tick :
                  (watchdog_tick &&
                   presc_ff[cfg_ff.prescale_ratio_field - 3'h1] &&
                   !nxt_presc[cfg_ff.prescale_ratio_field - 3'h1]);
  assign watchdog_timeout = wd_out_ff;

  // timer count; write loads, wrap sets the flag
  assign nxt_count = count_ff + CW'(1);
  // the set comes from the increment that leaves all ones
  assign flag_set  = inc && (count_ff == '1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else if (wr_acc && word == 10'(`TPU_COUNT_IDX)) begin
      count_ff <= pwdata[CW-1:0];
    end else if (inc) begin
      count_ff <= nxt_count;
    end
  end

  // overflow flag: write 1 to clear, a set in the same cycle wins
  assign flag_clr = wr_acc && word == 10'(`TPU_STATUS_IDX) && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // flag seen at Q1, then held off for the fixed latency
  // limitation: a flag left set keeps retriggering the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff     <= 3'h0;
      lat_run_ff <= 1'b0;
      timer_irq  <= 1'b0;
    end else begin
      timer_irq <= 1'b0;
      if (phase_ff == tpu_pkg::TPU_Q1) begin
        if (!lat_run_ff && flag_ff && irq_en_ff) begin
          lat_run_ff <= 1'b1;
          lat_ff     <= 3'h1;
        end else if (lat_run_ff) begin
          if (lat_ff == 3'(`TPU_IRQ_LATENCY)) begin
            timer_irq  <= 1'b1;
            lat_run_ff <= 1'b0;
          end else begin
            lat_ff <= lat_ff + 3'h1;
          end
        end
      end
    end
  end

  // external interrupt edge, sticky until status write clears
  assign eirq_edge = cfg_ff.ext_irq_edge_select ?
                     (!eirq_ff && ext_interrupt_pin) :
                     (eirq_ff && !ext_interrupt_pin);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eirq_ff      <= 1'b0;
      eirq_flag_ff <= 1'b0;
    end else begin
      eirq_ff <= ext_interrupt_pin;
      if (eirq_edge) begin
        eirq_flag_ff <= 1'b1;
      end else if (wr_acc && word == 10'(`TPU_STATUS_IDX) && pwdata[1]) begin
        eirq_flag_ff <= 1'b0;
      end
    end
  end
  assign ext_irq = eirq_flag_ff;

  // pull-ups follow the port latch unless globally disabled
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pu
      assign second_io_pullup_en[gi] = !cfg_ff.pullup_disable &&
                                       second_io_port_latch[gi];
    end
  endgenerate

  // read data registered at the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr[11:2])
        10'(`TPU_COUNT_IDX):  prdata <= {24'h00_0000, count_ff};
        10'(`TPU_CONFIG_IDX): prdata <= {24'h00_0000, cfg_ff};
        10'(`TPU_CTRL_IDX):   prdata <= {31'h0, irq_en_ff};
        10'(`TPU_STATUS_IDX): prdata <= {30'h0, eirq_flag_ff, flag_ff};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end
  // read strobe unused: read data is already loaded in the setup cycle
  logic unused_rd;
  assign unused_rd = rd_acc;
endmodule

// File: bench/tpu_timer_props.sv
// port-level assertion checker for the timer prescaler unit
`timescale 1ns/100ps
module tpu_timer_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        port4_out,
  input wire logic        port4_oe_n,
  input wire logic        watchdog_tick,
  input wire logic        watchdog_timeout,
  input wire logic        ext_interrupt_pin,
  input wire logic        ext_irq,
  input wire logic [7:0]  second_io_port_latch,
  input wire logic [7:0]  second_io_pullup_en,
  input wire logic        timer_irq,
  input wire logic        instr_clock_output
);
  logic [7:0] cfg_ff;
  wire        acc = psel && penable;
  wire        map = paddr inside {12'h004, 12'h204, 12'h008, 12'h00c};
  // shadow of the config register, follows accepted writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_ff <= 8'hff;
    else if (acc && pwrite && paddr == 12'h204) cfg_ff <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pullup_map: assert property (
    second_io_pullup_en == (second_io_port_latch & ~{8{cfg_ff[7]}}))
    else $error("pull-up enables do not follow latch and disable bit");
  chk_cfg_read: assert property (
    acc && !pwrite && paddr == 12'h204 |-> prdata[7:0] == cfg_ff)
    else $error("config read differs from last written value");
  chk_bad_addr: assert property (
    acc && !map |-> pslverr) else $error("unmapped access not refused");
  chk_good_addr: assert property (
    acc && map |-> !pslverr) else $error("mapped access refused");
  chk_open_drain: assert property (
    port4_oe_n == port4_out) else $error("clock pin drive not open drain");
  chk_instr_phase: assert property (
    $rose(instr_clock_output) |-> instr_clock_output[*2]
      ##1 !instr_clock_output[*2] ##1 instr_clock_output)
    else $error("instruction clock not two high then two low");
  chk_irq_pulse: assert property (
    timer_irq |=> !timer_irq) else $error("timer interrupt longer than one");
  chk_wdt_undiv: assert property (
    watchdog_tick && cfg_ff[3] && cfg_ff[2:0] == 3'h0 |=> watchdog_timeout)
    else $error("watchdog 1:1 tick not passed on");
  chk_wdt_cause: assert property (
    watchdog_timeout |-> $past(watchdog_tick))
    else $error("watchdog timeout without a tick");
  chk_wdt_bypass: assert property (
    watchdog_tick && !cfg_ff[3] |=> watchdog_timeout)
    else $error("watchdog tick lost without postscaler");
  chk_ext_edge: assert property (
    cfg_ff[6] && $rose(ext_interrupt_pin) |-> ##[1:4] ext_irq)
    else $error("rising external edge not flagged");
endmodule

// File: bench/tpu_clk_src.sv
// external clock source model driving the timer clock pin
`timescale 1ns/100ps
module tpu_clk_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [11:0] toggles,
  output logic             pin,
  output logic             busy
);
  logic [11:0] left_ff;
  logic        ph_ff;
  logic        pin_ff;
  // each level held two clocks, so the period is four; stands still after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 12'h000;
      ph_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else if (start) begin
      left_ff <= toggles;
      ph_ff <= 1'b0;
    end else if (left_ff != 12'h000) begin
      ph_ff <= ~ph_ff;
      if (ph_ff) begin
        pin_ff <= ~pin_ff;
        left_ff <= left_ff - 12'h001;
      end
    end
  end
  assign pin = pin_ff;
  assign busy = (left_ff != 12'h000);
endmodule

// File: bench/tb_tpu_timer.sv
// self-checking testbench for the timer prescaler unit
`timescale 1ns/100ps
module tb_tpu_timer;
  typedef struct { logic [7:0] cfg, latch, pu; } tpu_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, src_tog = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, er, port4_in, port4_out = 1, port4_oe_n;
  logic        watchdog_tick = 0, watchdog_clear_instr = 0;
  logic        ext_interrupt_pin = 0, src_start = 0, src_pin, src_busy;
  logic [7:0]  second_io_port_latch = 8'h00, second_io_pullup_en;
  logic        watchdog_timeout, timer_irq, ext_irq, instr_clock_output;
  int          n_fail = 0, n_tests = 0, cyc = 0, n_irq = 0, n_wdt = 0;
  tpu_row_t    rows [5] = '{'{8'h00, 8'ha5, 8'ha5}, '{8'h80, 8'hff, 8'h00},
    '{8'h7f, 8'h3c, 8'h3c}, '{8'hff, 8'hff, 8'h00}, '{8'h5a, 8'hc3, 8'hc3}};
  always #4 pclk = ~pclk;
  // open-drain pin: low whenever the design drives it
  assign port4_in = port4_oe_n ? src_pin : 1'b0;
  tpu_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port4_in(port4_in), .port4_out(port4_out), .port4_oe_n(port4_oe_n),
    .watchdog_tick(watchdog_tick), .watchdog_clear_instr(watchdog_clear_instr),
    .ext_interrupt_pin(ext_interrupt_pin),
    .second_io_port_latch(second_io_port_latch),
    .second_io_pullup_en(second_io_pullup_en),
    .watchdog_timeout(watchdog_timeout), .timer_irq(timer_irq),
    .ext_irq(ext_irq), .instr_clock_output(instr_clock_output));
  tpu_clk_src src (.pclk(pclk), .presetn(presetn), .start(src_start),
    .toggles(src_tog), .pin(src_pin), .busy(src_busy));
  // pulse counters and the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (timer_irq === 1'b1) n_irq++;
    if (watchdog_timeout === 1'b1) n_wdt++;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end
  task end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task ck(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input logic clr);
    @(posedge pclk);
    if (clr) watchdog_clear_instr <= 1'b1;
    else watchdog_tick <= 1'b1;
    @(posedge pclk);
    watchdog_clear_instr <= 1'b0;
    watchdog_tick <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // clear count (prescaler too while the timer owns it), send pin toggles, read back the count
  task run(input logic [11:0] t);
    // let a config change settle before the clearing write
    repeat (8) @(posedge pclk);
    apb(1, 12'h004, 8'h00);
    @(posedge pclk);
    src_start <= 1'b1;
    src_tog <= t;
    @(posedge pclk);
    src_start <= 1'b0;
    repeat (2) @(posedge pclk);
    while (src_busy) @(posedge pclk);
    repeat (16) @(posedge pclk);
    apb(0, 12'h004, 8'h00);
  endtask
  initial begin
    int i0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h204, 8'h00);
    ck(rd[7:0], 8'hff);
    foreach (rows[i]) begin
      apb(1, 12'h204, rows[i].cfg);
      second_io_port_latch <= rows[i].latch;
      apb(0, 12'h204, 8'h00);
      ck(rd[7:0], rows[i].cfg);
      ck(second_io_pullup_en, rows[i].pu);
    end
    apb(1, 12'h010, 8'hff);
    ck({7'h00, er}, 8'h01);
    apb(0, 12'h010, 8'h00);
    ck(rd[7:0], 8'h00);
    // internal source: undivided, then divided by two
    for (int k = 0; k < 2; k++) begin
      apb(1, 12'h204, k ? 8'h00 : 8'h08);
      apb(1, 12'h004, 8'h00);
      repeat (80) @(posedge pclk);
      apb(0, 12'h004, 8'h00);
      ck(8'(rd[7:0] >= (k ? 9 : 19) && rd[7:0] <= (k ? 11 : 22)), 1);
    end
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h204, 8'h20 | 8'(c));
      run(12'(3 << (c + 2)));
      ck(rd[7:0], 8'h03);
    end
    for (int e = 1; e >= 0; e--) begin
      apb(1, 12'h204, e ? 8'h38 : 8'h28);
      run(12'h005);
      ck(rd[7:0], 8'h02);
    end
    apb(1, 12'h204, 8'h08);
    apb(1, 12'h008, 8'h01);
    i0 = n_irq;
    apb(1, 12'h004, 8'hfe);
    repeat (40) @(posedge pclk);
    ck(8'(n_irq - i0), 8'h01);
    apb(0, 12'h00c, 8'h00);
    ck({7'h00, rd[0]}, 8'h01);
    apb(1, 12'h00c, 8'h01);
    apb(0, 12'h00c, 8'h00);
    ck({7'h00, rd[0]}, 8'h00);
    apb(1, 12'h008, 8'h00);
    for (int m = 1; m >= 0; m--) begin
      ext_interrupt_pin <= 1'(m);
      apb(1, 12'h204, m ? 8'h48 : 8'h08);
      apb(1, 12'h00c, 8'h02);
      ext_interrupt_pin <= !1'(m);
      repeat (8) @(posedge pclk);
      apb(0, 12'h00c, 8'h00);
      ck({7'h00, rd[1]}, 8'h00);
      ext_interrupt_pin <= 1'(m);
      repeat (8) @(posedge pclk);
      apb(0, 12'h00c, 8'h00);
      ck({7'h00, rd[1]}, 8'h01);
    end
    apb(1, 12'h204, 8'h08);
    i0 = n_wdt;
    wt(0);
    ck(8'(n_wdt - i0), 8'h01);
    apb(1, 12'h204, 8'h09);
    wt(1);
    wt(0);
    wt(1);
    wt(0);
    ck(8'(n_wdt - i0), 8'h01);
    wt(0);
    ck(8'(n_wdt - i0), 8'h02);
    apb(1, 12'h204, 8'h00);
    wt(0);
    ck(8'(n_wdt - i0), 8'h03);
    port4_out <= 1'b0;
    repeat (2) @(posedge pclk);
    ck({7'h00, port4_oe_n}, 8'h00);
    port4_out <= 1'b1;
    apb(1, 12'h204, 8'h12);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h204, 8'h00);
    ck(rd[7:0], 8'hff);
    end_sim();
  end
endmodule
bind tpu_timer tpu_timer_props chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .port4_out(port4_out), .port4_oe_n(port4_oe_n),
  .watchdog_tick(watchdog_tick), .watchdog_timeout(watchdog_timeout),
  .ext_interrupt_pin(ext_interrupt_pin), .ext_irq(ext_irq),
  .second_io_port_latch(second_io_port_latch),
  .second_io_pullup_en(second_io_pullup_en), .timer_irq(timer_irq),
  .instr_clock_output(instr_clock_output));
